// ### threshold_input_conditioner_bench.sv
// self-checking bench for the threshold input conditioner
`timescale 1ns/1ns
`default_nettype none
module threshold_input_conditioner_bench;
  import tic_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, f_wr = 0, pready, perr, irq;
  logic [11:0] paddr = '0, f_v = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic [2:0] f_ch = '0;
  logic ce = 1;
  logic [7:0] st;
  tic_volt_arr_type volt;
  int bad_count = 0, check_count = 0, cyc = 0;
  always #10 clk = ~clk;
  tic_field_model u_tic_field_model (.i_mclk(clk), .i_wr(f_wr), .i_ch(f_ch), .i_mv(f_v), .o_volt(volt));
  tic_top #(.P_TICK_CYC(20)) u_tic_top (.i_mclk(clk), .i_arst_n(rst_n), .i_ce(ce), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_volt(volt),
    .o_pready(pready), .o_pslverr(perr), .o_prdata(prdata), .o_state(st), .o_irq(irq));
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      stop_test;
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic e);
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = perr;
    psel <= 0;
    pen <= 0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic e;
    apb(1, a, d, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input string n);
    logic e;
    apb(0, a, 0, e);
    chk(n, x, r);
  endtask
  task automatic setv(input logic [2:0] c, input logic [11:0] v);
    @(posedge clk);
    f_wr <= 1;
    f_ch <= c;
    f_v <= v;
    @(posedge clk);
    f_wr <= 0;
  endtask
  task automatic ticks(input int n);
    repeat (n * 20) @(posedge clk);
  endtask
  task automatic stat(input logic [7:0] x);
    @(posedge clk);
    chk("state", {24'h0, x}, {24'h0, st});
  endtask
  function automatic logic [11:0] ca(input int c, input int o);
    return 12'(32'h100 + c * 32 + o);
  endfunction
  logic e;
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1;
    repeat (4) @(posedge clk);
    for (int c = 0; c < 8; c++) begin
      rd(ca(c, 0), 32'h370, "act");
      rd(ca(c, 4), 32'h258, "rel");
      rd(ca(c, 8), 32'h0, "cfg");
      rd(ca(c, 12), 32'h0, "pick");
      rd(ca(c, 20), 32'h0, "count");
    end
    wr(ca(7, 0), 32'h10);
    rd(ca(7, 0), 32'h0A0, "act clamp");
    apb(0, 12'h0FC, 0, e);
    chk("unmapped err", 1, {31'h0, e});
    apb(0, 12'h002, 0, e);
    chk("misaligned err", 1, {31'h0, e});
    $display("test registers done");
    wr(12'h008, 32'h1);
    setv(0, 12'd900);
    ticks(2);
    stat(8'h01);
    chk("irq", 1, {31'h0, irq});
    rd(12'h004, 32'h1, "irq stat");
    stat(8'h01);
    chk("irq cleared", 0, {31'h0, irq});
    setv(0, 12'd700);
    ticks(2);
    stat(8'h01);
    setv(0, 12'd500);
    ticks(2);
    stat(8'h00);
    rd(12'h004, 32'h100, "irq fall");
    setv(0, 12'd900);
    ticks(2);
    rd(ca(0, 20), 32'h2, "count");
    wr(ca(0, 20), 32'h0);
    rd(ca(0, 20), 32'h0, "count clr");
    $display("test polarity open done");
    wr(ca(1, 8), 32'h1);
    ticks(2);
    stat(8'h03);
    setv(1, 12'd900);
    ticks(2);
    stat(8'h01);
    $display("test polarity closed done");
    wr(ca(2, 12), 32'd10);
    setv(2, 12'd900);
    ticks(1);
    stat(8'h01);
    setv(2, 12'd0);
    ticks(5);
    stat(8'h01);
    setv(2, 12'd900);
    ticks(5);
    stat(8'h05);
    $display("test delays done");
    wr(ca(3, 8), 32'h2);
    setv(3, 12'd900);
    ticks(2);
    setv(3, 12'd500);
    ticks(3);
    stat(8'h0D);
    setv(3, 12'd50);
    ticks(3);
    stat(8'h0D);
    ticks(10);
    stat(8'h05);
    $display("test ac mode done");
    @(posedge clk);
    ce <= 0;
    setv(4, 12'd900);
    ticks(3);
    stat(8'h05);
    ce <= 1;
    ticks(2);
    stat(8'h15);
    $display("test clock enable done");
    wr(ca(5, 16), 32'd10);
    setv(5, 12'd900);
    ticks(2);
    stat(8'h35);
    setv(5, 12'd0);
    ticks(1);
    stat(8'h35);
    ticks(3);
    stat(8'h15);
    $display("test drop delay done");
    stop_test;
  end
endmodule
`default_nettype wire

// ### tic_defs.svh
// constants for the threshold input conditioner
`ifndef TIC_DEFS_SVH
`define TIC_DEFS_SVH
`define TIC_NCH 8
`define TIC_VW 12
`define TIC_DW 21
`define TIC_TW 22
`define TIC_CW 32
`define TIC_AW 12
`define TIC_TICKW 18
`define TIC_CLK_KHZ 50000
`define TIC_TICK_MS 5
`define TIC_TICK_CYC (`TIC_TICK_MS * `TIC_CLK_KHZ)
`define TIC_AC_MS 30
`define TIC_AC_DIV 10
`define TIC_ACT_RST 12'h370
`define TIC_ACT_MIN 12'h0A0
`define TIC_REL_RST 12'h258
`define TIC_REL_MIN 12'h064
`define TIC_THR_MAX 12'h7D0
`define TIC_DLY_MAX 21'h1B7740
`define TIC_PAGE_GLOB 4'h0
`define TIC_PAGE_CHAN 4'h1
`define TIC_G_STATE 3'h0
`define TIC_G_IRQ 3'h1
`define TIC_G_MASK 3'h2
`define TIC_G_NUM 3'h3
`define TIC_C_ACT 3'h0
`define TIC_C_REL 3'h1
`define TIC_C_CFG 3'h2
`define TIC_C_PICK 3'h3
`define TIC_C_DROP 3'h4
`define TIC_C_CNT 3'h5
`define TIC_C_NUM 3'h6
`define TIC_CFG_NC 0
`define TIC_CFG_AC 1
`endif

// ### tic_field_model.sv
// field wiring model: per-channel measured voltage seen by the conditioner
`timescale 1ns/1ns
`default_nettype none
module tic_field_model (
  input wire logic i_mclk,
  input wire logic i_wr,
  input wire logic [2:0] i_ch,
  input wire logic [11:0] i_mv,
  output var tic_pkg::tic_volt_arr_type o_volt
);
  import tic_pkg::*;
  initial o_volt = '0;
  // a measurement holds until the bench moves that channel
  always @(posedge i_mclk) begin
    if (i_wr) begin
      o_volt[i_ch] <= i_mv;
    end
  end
endmodule
`default_nettype wire

// ### tic_pkg.sv
// types shared by the threshold input conditioner
`include "tic_defs.svh"
package tic_pkg;
  typedef logic [`TIC_VW-1:0] tic_volt_type;
  typedef tic_volt_type [`TIC_NCH-1:0] tic_volt_arr_type;
  typedef struct packed {
    logic [`TIC_VW-1:0] act;
    logic [`TIC_VW-1:0] rel;
    logic nc;
    logic ac;
    logic [`TIC_DW-1:0] pick;
    logic [`TIC_DW-1:0] drop;
  } tic_cfg_type;
  typedef struct packed {
    logic energ;
    logic qual;
    logic [`TIC_TW-1:0] tmr;
    logic [`TIC_CW-1:0] cnt;
  } tic_chst_type;
  typedef struct packed {
    logic ok;
    logic glob;
    logic [2:0] ch;
    logic [2:0] idx;
  } tic_dec_type;
endpackage

// ### tic_top.sv
// eight channel threshold input conditioner with apb registers
`timescale 1ns/1ns
`default_nettype none
`include "tic_defs.svh"
module tic_top #(
  parameter int unsigned P_TICK_CYC = `TIC_TICK_CYC
) (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [`TIC_AW-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire tic_pkg::tic_volt_arr_type i_volt,
  output logic o_pready,
  output logic o_pslverr,
  output logic [31:0] o_prdata,
  output logic [`TIC_NCH-1:0] o_state,
  output logic o_irq
);
  import tic_pkg::*;

  function automatic tic_dec_type tic_decode(input logic [`TIC_AW-1:0] a);
    tic_dec_type d;
    d.ch = a[7:5];
    d.idx = a[4:2];
    d.glob = (a[11:8] == `TIC_PAGE_GLOB);
    d.ok = (a[1:0] == 2'h0) && ((d.glob && a[7:5] == 3'h0 && d.idx < `TIC_G_NUM) ||
           (a[11:8] == `TIC_PAGE_CHAN && d.idx < `TIC_C_NUM));
    return d;
  endfunction

  function automatic logic [31:0] tic_clamp(input logic [31:0] v, input logic [31:0] lo,
                                            input logic [31:0] hi);
    logic [31:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction

  // reset release through two flops
  logic [1:0] rsync_q;
  logic rst_n;
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rsync_q <= 2'h0;
    end else begin
      rsync_q <= {rsync_q[0], 1'b1};
    end
  end
  assign rst_n = rsync_q[1];

  // scan tick
  logic [`TIC_TICKW-1:0] tcnt_q, tcnt_d;
  logic tick_q, tick_d;
  always_comb begin
    tick_d = 1'b0;
    tcnt_d = tcnt_q + `TIC_TICKW'(1);
    if (tcnt_q == `TIC_TICKW'(P_TICK_CYC - 1)) begin
      tcnt_d = '0;
      tick_d = 1'b1;
    end
  end
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      tcnt_q <= '0;
      tick_q <= 1'b0;
    end else if (i_ce) begin
      tcnt_q <= tcnt_d;
      tick_q <= tick_d;
    end
  end

  // registers and channel state
  tic_cfg_type [`TIC_NCH-1:0] cfg_q, cfg_d;
  tic_chst_type [`TIC_NCH-1:0] st_q, st_d;
  logic [2*`TIC_NCH-1:0] stat_q, stat_d, mask_q, mask_d;
  logic [`TIC_NCH-1:0] raw_w;
  logic [31:0] prdata_d;
  logic pready_d, pslverr_d, irq_d;
  logic [`TIC_NCH-1:0] state_d;
  tic_dec_type dec;
  logic wr, rd;

  always_comb begin
    logic [`TIC_VW-1:0] rel_eff;
    logic en_n;
    logic [`TIC_TW-1:0] lim;
    rel_eff = '0;
    en_n = 1'b0;
    lim = '0;
    cfg_d = cfg_q;
    st_d = st_q;
    stat_d = stat_q;
    mask_d = mask_q;
    raw_w = '0;
    dec = tic_decode(i_paddr);
    wr = i_psel && i_penable && o_pready && i_pwrite && dec.ok;
    rd = i_psel && i_penable && o_pready && !i_pwrite && dec.ok;
    if (wr && dec.glob) begin
      if (dec.idx == `TIC_G_MASK) begin
        mask_d = i_pwdata[2*`TIC_NCH-1:0];
      end
    end else if (wr) begin
      case (dec.idx)
        `TIC_C_ACT: cfg_d[dec.ch].act = `TIC_VW'(tic_clamp(i_pwdata, 32'(`TIC_ACT_MIN),
                                         32'(`TIC_THR_MAX)));
        `TIC_C_REL: cfg_d[dec.ch].rel = `TIC_VW'(tic_clamp(i_pwdata, 32'(`TIC_REL_MIN),
                                         32'(`TIC_THR_MAX)));
        `TIC_C_CFG: begin
          cfg_d[dec.ch].nc = i_pwdata[`TIC_CFG_NC];
          cfg_d[dec.ch].ac = i_pwdata[`TIC_CFG_AC];
        end
        `TIC_C_PICK: cfg_d[dec.ch].pick = `TIC_DW'(tic_clamp(i_pwdata, 32'h0, 32'(`TIC_DLY_MAX)));
        `TIC_C_DROP: cfg_d[dec.ch].drop = `TIC_DW'(tic_clamp(i_pwdata, 32'h0, 32'(`TIC_DLY_MAX)));
        `TIC_C_CNT: st_d[dec.ch].cnt = '0;
        default: ;
      endcase
    end
    // read clears the event flags; events below still set
    if (rd && dec.glob && dec.idx == `TIC_G_IRQ) begin
      stat_d = '0;
    end
    for (int c = 0; c < `TIC_NCH; c++) begin
      rel_eff = cfg_q[c].ac ? `TIC_VW'(cfg_q[c].act / `TIC_AC_DIV) : cfg_q[c].rel;
      en_n = st_q[c].energ;
      if (i_volt[c] > cfg_q[c].act) begin
        en_n = 1'b1;
      end else if (i_volt[c] < rel_eff) begin
        en_n = 1'b0;
      end
      raw_w[c] = en_n ^ cfg_q[c].nc;
      if (st_q[c].qual) begin
        lim = `TIC_TW'(cfg_q[c].drop) + (cfg_q[c].ac ? `TIC_TW'(`TIC_AC_MS) : '0);
      end else begin
        lim = `TIC_TW'(cfg_q[c].pick);
      end
      if (tick_q) begin
        st_d[c].energ = en_n;
        if (raw_w[c] == st_q[c].qual) begin
          st_d[c].tmr = '0;
        end else if (st_q[c].tmr >= lim) begin
          st_d[c].qual = raw_w[c];
          st_d[c].tmr = '0;
          if (raw_w[c]) begin
            st_d[c].cnt = st_d[c].cnt + `TIC_CW'(1);
            stat_d[c] = 1'b1;
          end else begin
            stat_d[`TIC_NCH+c] = 1'b1;
          end
        end else begin
          st_d[c].tmr = st_q[c].tmr + `TIC_TW'(`TIC_TICK_MS);
        end
      end
      state_d[c] = st_d[c].qual;
    end
    irq_d = |(stat_d & mask_d);
  end

  // apb answer: zero wait states, data prepared in the setup cycle
  always_comb begin
    prdata_d = '0;
    pready_d = i_psel && !i_penable;
    pslverr_d = i_psel && !i_penable && !dec.ok;
    if (pready_d && !i_pwrite && dec.ok) begin
      if (dec.glob) begin
        case (dec.idx)
          `TIC_G_STATE: prdata_d = 32'(o_state);
          `TIC_G_IRQ: prdata_d = 32'(stat_q);
          `TIC_G_MASK: prdata_d = 32'(mask_q);
          default: prdata_d = '0;
        endcase
      end else begin
        case (dec.idx)
          `TIC_C_ACT: prdata_d = 32'(cfg_q[dec.ch].act);
          `TIC_C_REL: prdata_d = 32'(cfg_q[dec.ch].rel);
          `TIC_C_CFG: prdata_d = 32'({cfg_q[dec.ch].ac, cfg_q[dec.ch].nc});
          `TIC_C_PICK: prdata_d = 32'(cfg_q[dec.ch].pick);
          `TIC_C_DROP: prdata_d = 32'(cfg_q[dec.ch].drop);
          `TIC_C_CNT: prdata_d = st_q[dec.ch].cnt;
          default: prdata_d = '0;
        endcase
      end
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < `TIC_NCH; c++) begin
        cfg_q[c] <= '{act: `TIC_ACT_RST, rel: `TIC_REL_RST, nc: 1'b0, ac: 1'b0,
                      pick: '0, drop: '0};
      end
      st_q <= '0;
      stat_q <= '0;
      mask_q <= '0;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= '0;
      o_state <= '0;
      o_irq <= 1'b0;
    end else if (i_ce) begin
      cfg_q <= cfg_d;
      st_q <= st_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      o_pready <= pready_d;
      o_pslverr <= pslverr_d;
      o_prdata <= prdata_d;
      o_state <= state_d;
      o_irq <= irq_d;
    end
  end

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!rst_n);

  tick_period_a: assert property (
    (i_ce && tcnt_q == `TIC_TICKW'(P_TICK_CYC - 1)) |=> tick_q ##1 (!tick_q || !$past(i_ce)))
    else $error("scan tick not issued at period end");
  act_range_a: assert property (
    cfg_q[0].act >= `TIC_ACT_MIN && cfg_q[0].act <= `TIC_THR_MAX)
    else $error("activation threshold out of range");
  rel_range_a: assert property (
    cfg_q[0].rel >= `TIC_REL_MIN && cfg_q[0].rel <= `TIC_THR_MAX)
    else $error("release threshold out of range");
  above_act_a: assert property (
    (i_ce && tick_q && i_volt[0] > cfg_q[0].act) |=> st_q[0].energ)
    else $error("voltage above activation not seen as energised");
  polarity_map_a: assert property (
    (i_ce && $changed(st_q[0].qual)) |-> st_q[0].qual == (st_q[0].energ ^ $past(cfg_q[0].nc)))
    else $error("qualified state disagrees with polarity");
  pick_delay_a: assert property (
    $rose(st_q[0].qual) |-> $past(st_q[0].tmr) >= 22'($past(cfg_q[0].pick)))
    else $error("rising change before activation delay");
  drop_delay_a: assert property (
    $fell(st_q[0].qual) |-> $past(st_q[0].tmr) >=
      22'($past(cfg_q[0].drop)) + ($past(cfg_q[0].ac) ? 22'(`TIC_AC_MS) : 22'h0))
    else $error("falling change before drop-off delay");
  count_rise_a: assert property (
    $rose(st_q[0].qual) |-> (st_q[0].cnt == 32'($past(st_q[0].cnt) + 1) || st_q[0].cnt == 32'h1))
    else $error("counter did not follow rising change");
  count_clear_a: assert property (
    (i_ce && !tick_q && wr && !dec.glob && dec.ch == 3'h0 && dec.idx == `TIC_C_CNT)
      |=> st_q[0].cnt == 32'h0)
    else $error("counter not cleared");
  cancel_pending_a: assert property (
    (i_ce && tick_q && raw_w[0] == st_q[0].qual) |=> st_q[0].tmr == 22'h0 && $stable(st_q[0].qual))
    else $error("pending change not cancelled");

  rel_low_a: assert property (
    (i_ce && tick_q && !cfg_q[0].ac && i_volt[0] < cfg_q[0].rel && i_volt[0] <= cfg_q[0].act)
      |=> !st_q[0].energ)
    else $error("voltage below release not seen as released");
  nc_invert_a: assert property (
    (i_ce && tick_q && !wr && cfg_q[1].nc && i_volt[1] > cfg_q[1].act)
      |=> !(st_q[1].energ ^ cfg_q[1].nc))
    else $error("closed polarity did not invert energised input");
  reset_cfg_a: assert property (
    $rose(rst_n) |-> !cfg_q[0].nc && !cfg_q[0].ac && cfg_q[0].act == `TIC_ACT_RST &&
      cfg_q[0].rel == `TIC_REL_RST)
    else $error("channel settings not at reset defaults");
  drop_rule_a: assert property (
    $fell(st_q[5].qual) |-> $past(st_q[5].tmr) >= 22'($past(cfg_q[5].drop)))
    else $error("falling change before drop-off time");
  ac_release_a: assert property (
    (i_ce && tick_q && cfg_q[3].ac && 32'(i_volt[3]) * `TIC_AC_DIV + `TIC_AC_DIV <= 32'(cfg_q[3].act))
      |=> !st_q[3].energ)
    else $error("ac release not at a tenth of activation");
  rise_flag_a: assert property (
    $rose(st_q[0].qual) |-> stat_q[0])
    else $error("rising change left no event flag");
  band_hold_a: assert property (
    (i_ce && tick_q && !cfg_q[0].ac && i_volt[0] <= cfg_q[0].act && i_volt[0] >= cfg_q[0].rel)
      |=> $stable(st_q[0].energ))
    else $error("raw state moved inside hysteresis band");
  count_wrap_a: assert property (
    (i_ce && tick_q && !wr && raw_w[0] && !st_q[0].qual && st_q[0].tmr >= 22'(cfg_q[0].pick) &&
      st_q[0].cnt == 32'hFFFFFFFF) |=> st_q[0].cnt == 32'h0)
    else $error("counter did not wrap to zero");
  ce_freeze_a: assert property (
    !i_ce |=> $stable(st_q) && $stable(tcnt_q) && $stable(o_state))
    else $error("state moved while clock enable low");

  // the same checks on every channel
  for (genvar g = 0; g < `TIC_NCH; g++) begin : g_chan_chk
    state_out_a: assert property (
      o_state[g] == st_q[g].qual)
      else $error("state output differs from channel state");
    chan_pick_a: assert property (
      $rose(st_q[g].qual) |-> $past(st_q[g].tmr) >= 22'($past(cfg_q[g].pick)))
      else $error("channel rose before activation delay");
    chan_drop_a: assert property (
      $fell(st_q[g].qual) |-> $past(st_q[g].tmr) >= 22'($past(cfg_q[g].drop)))
      else $error("channel fell before drop-off time");
    chan_cancel_a: assert property (
      (i_ce && tick_q && raw_w[g] == st_q[g].qual) |=> $stable(st_q[g].qual))
      else $error("channel changed although raw state agreed");
  end
endmodule
`default_nettype wire
